// File: verilog/exc_power_unit.sv
// exception, break and low-power control with avalon-mm status registers
// Notes on behaviour
// RULE1: software interrupt is taken whatever the interrupt mask says.
// RULE2: software interrupt stacks pc; hardware interrupt stacks pc minus one.
// RULE3: fixed priority: reset, software, then sources one to twenty.
// RULE4: low status register holds flags six to one in bits seven to two.
// RULE5: mid status register holds flags fourteen to seven in all bits.
// RULE6: high status register holds flags twenty to fifteen, top bits zero.
// RULE7: a flag reads one exactly while its source is requesting.
// RULE8: every reset source acts at once with equal top priority.
// RULE9: break request forces the cpu to the software interrupt vector.
// RULE10: in break, other flags clear only while clear-enable is set.
// RULE11: a flag cleared in break stays cleared after break ends.
// RULE12: two-step clears stay protected in break; after break they work.
// RULE13: wait or stop clears the interrupt mask and stops cpu clock.
// RULE14: wait gates cpu clock, peripheral clock keeps running.
// RULE15: enabled interrupt wakes from wait; stacking starts next cycle.
// RULE16: wait ends on reset or break; break sets wait-exit flag. Here break ends wait only while EMULATION_MODE is set.
// RULE17: watchdog runs, also in wait, while its disable option is zero.
// RULE18: entering stop resets the recovery counter and stops system clocks.
// RULE19: stop gates both bus clock and crystal clock outputs.
// RULE20: stop ends on interrupt or reset; stacking after recovery time.
// RULE21: recovery is 4096 crystal cycles, or 32 with short option.
// RULE22: counter held reset in stop, then counts out recovery.
// RULE23: hardware interrupt taken at instruction end if unmasked and enabled.
// RULE24: status register writes are ignored; reads change nothing.
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/1ns
module exc_power_unit #(
    parameter int NSRC = exc_pkg::NUM_SRC,
    parameter int REC_LONG = exc_pkg::STOP_REC_LONG,
    parameter int REC_SHORT = exc_pkg::STOP_REC_SHORT
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // avalon-mm slave
    input wire logic [15:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [7:0] AVS_WRITEDATA,
    output logic [7:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    // interrupt sources and enables
    input wire logic [NSRC-1:0] IRQ_PENDING,
    input wire logic [NSRC-1:0] IRQ_ENABLE,
    input wire logic RESET_REQ,
    // cpu side
    input wire exc_pkg::cpu_req_t CPU_REQ,
    output exc_pkg::cpu_ans_t CPU_ANS,
    // break module
    input wire logic BREAK_IRQ,
    input wire logic BREAK_ACTIVE,
    input wire logic EMULATION_MODE,
    // flag protection towards other modules
    input wire logic FLAG_CLEAR_REQ,
    output logic FLAG_CLEAR_ALLOW,
    // clock gating and watchdog
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic BUS_CLK_EN,
    output logic XTAL_CLK_EN,
    output logic WATCHDOG_EN,
    output logic [1:0] POWER_STATE
);
    typedef struct packed {
        exc_pkg::power_state_t pm;
        logic [12:0] rec_cnt;
        logic [7:0] option;
        logic clear_en;
        logic wait_exit;
        logic [7:0] rdata;
        logic rvalid;
        exc_pkg::cpu_ans_t ans;
    } state_t;

    state_t s_q;
    state_t s_d;
    logic [NSRC-1:0] live;
    logic [7:0] pend_low;
    logic [7:0] pend_mid;
    logic [7:0] pend_high;
    logic [4:0] first_idx;
    logic any_hw;
    logic rec_done;
    logic [12:0] rec_len;

    // pending flags follow the sources directly
    assign live = IRQ_PENDING;
    assign pend_low = {live[5:0], 2'h0}; // RULE4 RULE7
    assign pend_mid = live[13:6]; // RULE5 RULE7
    assign pend_high = {2'h0, live[19:14]}; // RULE6 RULE7

    // lowest index enabled request wins
    always_comb begin
        first_idx = 5'h00;
        any_hw = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (live[i] && IRQ_ENABLE[i]) begin // RULE3 RULE23
                first_idx = 5'(i);
                any_hw = 1'b1;
            end
        end
    end

    assign rec_len = s_q.option[exc_pkg::POS_SHORT_STOP] ?
        13'(REC_SHORT) : 13'(REC_LONG); // RULE21
    assign rec_done = s_q.rec_cnt == rec_len - 13'h0001;

    always_comb begin
        s_d = s_q;
        s_d.ans.take_int = 1'b0;
        s_d.ans.clear_mask = 1'b0;
        s_d.ans.enter_break = 1'b0;
        s_d.rvalid = 1'b0;
        // avalon register access, one wait cycle on reads
        if (AVS_WRITE) begin
            unique case (AVS_ADDRESS)
                exc_pkg::OFS_BRK_FLAG_CTRL:
                    s_d.clear_en = AVS_WRITEDATA[exc_pkg::POS_BRK_CLEAR_EN];
                exc_pkg::OFS_OPTION: s_d.option = AVS_WRITEDATA;
                exc_pkg::OFS_BRK_STATUS: begin
                    if (!AVS_WRITEDATA[exc_pkg::POS_BRK_WAIT_EXIT]) begin
                        s_d.wait_exit = 1'b0;
                    end
                end
                default: s_d.option = s_q.option; // RULE24
            endcase
        end
        if (AVS_READ && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            unique case (AVS_ADDRESS)
                exc_pkg::OFS_PEND_LOW: s_d.rdata = pend_low; // RULE24
                exc_pkg::OFS_PEND_MID: s_d.rdata = pend_mid;
                exc_pkg::OFS_PEND_HIGH: s_d.rdata = pend_high;
                exc_pkg::OFS_BRK_STATUS:
                    s_d.rdata = {6'h00, s_q.wait_exit, 1'b0};
                exc_pkg::OFS_BRK_FLAG_CTRL:
                    s_d.rdata = {s_q.clear_en, 7'h00};
                exc_pkg::OFS_OPTION: s_d.rdata = s_q.option;
                default: s_d.rdata = exc_pkg::READ_UNMAPPED;
            endcase
        end
        // power state machine and exception choice
        unique case (s_q.pm)
            exc_pkg::PM_RUN: begin
                if (BREAK_IRQ && CPU_REQ.instr_end) begin // RULE9
                    s_d.ans.take_int = 1'b1;
                    s_d.ans.enter_break = 1'b1;
                    s_d.ans.vector = exc_pkg::VEC_SOFTWARE_INT;
                    s_d.ans.stack_pc = CPU_REQ.pc;
                end else if (CPU_REQ.swi_exec) begin // RULE1 RULE3
                    s_d.ans.take_int = 1'b1;
                    s_d.ans.vector = exc_pkg::VEC_SOFTWARE_INT;
                    s_d.ans.stack_pc = CPU_REQ.pc; // RULE2
                end else if (CPU_REQ.wait_exec) begin
                    s_d.pm = exc_pkg::PM_WAIT;
                    s_d.ans.clear_mask = 1'b1; // RULE13
                end else if (CPU_REQ.stop_exec) begin
                    s_d.pm = exc_pkg::PM_STOP;
                    s_d.ans.clear_mask = 1'b1; // RULE13
                    s_d.rec_cnt = 13'h0000; // RULE18
                end else if (CPU_REQ.instr_end && any_hw
                    && !CPU_REQ.int_mask) begin // RULE23
                    s_d.ans.take_int = 1'b1;
                    s_d.ans.vector = exc_pkg::VEC_SRC_BASE
                        - {10'h000, first_idx, 1'b0};
                    s_d.ans.stack_pc = CPU_REQ.pc - 16'h0001; // RULE2
                end
            end
            exc_pkg::PM_WAIT: begin
                if (BREAK_IRQ && EMULATION_MODE) begin // RULE16
                    s_d.pm = exc_pkg::PM_RUN;
                    s_d.wait_exit = 1'b1;
                    s_d.ans.take_int = 1'b1;
                    s_d.ans.enter_break = 1'b1;
                    s_d.ans.vector = exc_pkg::VEC_SOFTWARE_INT;
                    s_d.ans.stack_pc = CPU_REQ.pc;
                end else if (any_hw) begin // RULE15
                    s_d.pm = exc_pkg::PM_RUN;
                    s_d.ans.take_int = 1'b1;
                    s_d.ans.vector = exc_pkg::VEC_SRC_BASE
                        - {10'h000, first_idx, 1'b0};
                    s_d.ans.stack_pc = CPU_REQ.pc - 16'h0001;
                end
            end
            exc_pkg::PM_STOP: begin
                s_d.rec_cnt = 13'h0000; // RULE22
                if (any_hw) begin // RULE20
                    s_d.pm = exc_pkg::PM_RECOVER;
                end
            end
            exc_pkg::PM_RECOVER: begin
                s_d.rec_cnt = s_q.rec_cnt + 13'h0001; // RULE22
                if (rec_done) begin // RULE20 RULE21
                    s_d.pm = exc_pkg::PM_RUN;
                    s_d.rec_cnt = 13'h0000;
                    s_d.ans.take_int = any_hw;
                    s_d.ans.vector = exc_pkg::VEC_SRC_BASE
                        - {10'h000, first_idx, 1'b0};
                    s_d.ans.stack_pc = CPU_REQ.pc - 16'h0001;
                end
            end
        endcase
        // any reset source overrides power state, counter and the cpu vector without arbitration
        if (RESET_REQ) begin // RULE8 RULE16 RULE20
            s_d.pm = exc_pkg::PM_RUN;
            s_d.rec_cnt = 13'h0000;
            s_d.ans.take_int = 1'b1;
            s_d.ans.enter_break = 1'b0;
            s_d.ans.vector = exc_pkg::VEC_RESET;
            s_d.ans.stack_pc = CPU_REQ.pc;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            s_q <= '0;
            s_q.pm <= exc_pkg::PM_RUN;
            s_q.option <= exc_pkg::RST_OPTION;
            s_q.clear_en <=
                exc_pkg::RST_BRK_FLAG_CTRL[exc_pkg::POS_BRK_CLEAR_EN];
        end else begin
            s_q <= s_d;
        end
    end

    assign AVS_READDATA = s_q.rdata;
    assign AVS_WAITREQUEST = AVS_READ && !s_q.rvalid;
    assign CPU_ANS = s_q.ans;
    // protection: clears pass outside break or when enabled
    assign FLAG_CLEAR_ALLOW = FLAG_CLEAR_REQ
        && (!BREAK_ACTIVE || s_q.clear_en); // RULE10 RULE11 RULE12
    assign CPU_CLK_EN = s_q.pm == exc_pkg::PM_RUN; // RULE13 RULE14
    assign PERIPH_CLK_EN = s_q.pm != exc_pkg::PM_STOP; // RULE14 RULE19
    assign BUS_CLK_EN = s_q.pm != exc_pkg::PM_STOP; // RULE18 RULE19
    assign XTAL_CLK_EN = s_q.pm != exc_pkg::PM_STOP; // RULE19
    assign WATCHDOG_EN = !s_q.option[exc_pkg::POS_WDOG_DISABLE]; // RULE17
    assign POWER_STATE = s_q.pm;

    // recovery length counter check
    logic [12:0] rec_seen;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rec_seen <= 13'h0000;
        end else if (s_q.pm == exc_pkg::PM_RECOVER) begin
            rec_seen <= rec_seen + 13'h0001;
        end else begin
            rec_seen <= 13'h0000;
        end
    end

    sequence swi_seen;
        CPU_REQ.swi_exec && s_q.pm == exc_pkg::PM_RUN && !RESET_REQ
            && !(BREAK_IRQ && CPU_REQ.instr_end);
    endsequence
    sequence swi_taken;
        CPU_ANS.take_int && CPU_ANS.vector == exc_pkg::VEC_SOFTWARE_INT;
    endsequence

    chk_swi_nomask: assert property (@(posedge MCLK) disable iff (!RSTN)
        swi_seen |=> swi_taken) else $error("swi not taken"); // RULE1
    chk_swi_stack_pc: assert property (@(posedge MCLK) disable iff (!RSTN)
        swi_seen |=> CPU_ANS.stack_pc == $past(CPU_REQ.pc))
        else $error("swi stacked wrong pc"); // RULE2
    chk_pend_low_map: assert property (@(posedge MCLK) disable iff (!RSTN)
        pend_low[1:0] == 2'h0 && pend_low[7:2] == IRQ_PENDING[5:0])
        else $error("low status map wrong"); // RULE4
    chk_pend_high_map: assert property (@(posedge MCLK) disable iff (!RSTN)
        pend_high[7:6] == 2'h0 && pend_mid == IRQ_PENDING[13:6])
        else $error("mid or high status map wrong"); // RULE6
    chk_reset_wins: assert property (@(posedge MCLK) disable iff (!RSTN)
        RESET_REQ |=> CPU_ANS.vector == exc_pkg::VEC_RESET
            && s_q.pm == exc_pkg::PM_RUN)
        else $error("reset not immediate"); // RULE8
    chk_break_protect: assert property (@(posedge MCLK) disable iff (!RSTN)
        BREAK_ACTIVE && !s_q.clear_en |-> !FLAG_CLEAR_ALLOW)
        else $error("flag clear leaked in break"); // RULE10
    chk_wait_gating: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_q.pm == exc_pkg::PM_WAIT |-> !CPU_CLK_EN && PERIPH_CLK_EN)
        else $error("wait clock gating wrong"); // RULE14
    chk_stop_gating: assert property (@(posedge MCLK) disable iff (!RSTN)
        $rose(s_q.pm == exc_pkg::PM_STOP) |-> !BUS_CLK_EN && !XTAL_CLK_EN
            && s_q.rec_cnt == 13'h0000)
        else $error("stop entry wrong"); // RULE18
    chk_recover_len: assert property (@(posedge MCLK) disable iff (!RSTN)
        $fell(s_q.pm == exc_pkg::PM_RECOVER) && !$past(RESET_REQ)
            |-> $past(rec_seen) == rec_len - 13'h0001)
        else $error("stop recovery length wrong"); // RULE21

    // low-power entry and exit steps, break and hardware interrupt taking
    sequence run_wait_exec;
        s_q.pm == exc_pkg::PM_RUN && CPU_REQ.wait_exec && !CPU_REQ.swi_exec
            && !(BREAK_IRQ && CPU_REQ.instr_end) && !RESET_REQ;
    endsequence
    sequence run_stop_exec;
        s_q.pm == exc_pkg::PM_RUN && CPU_REQ.stop_exec && !CPU_REQ.swi_exec
            && !CPU_REQ.wait_exec && !(BREAK_IRQ && CPU_REQ.instr_end)
            && !RESET_REQ;
    endsequence
    sequence wait_wake;
        s_q.pm == exc_pkg::PM_WAIT && any_hw && !RESET_REQ
            && !(BREAK_IRQ && EMULATION_MODE);
    endsequence
    sequence wait_break;
        s_q.pm == exc_pkg::PM_WAIT && BREAK_IRQ && EMULATION_MODE
            && !RESET_REQ;
    endsequence
    sequence run_break;
        s_q.pm == exc_pkg::PM_RUN && BREAK_IRQ && CPU_REQ.instr_end
            && !RESET_REQ;
    endsequence
    sequence run_hw_take;
        s_q.pm == exc_pkg::PM_RUN && CPU_REQ.instr_end && any_hw
            && !CPU_REQ.int_mask && !CPU_REQ.swi_exec && !CPU_REQ.wait_exec
            && !CPU_REQ.stop_exec && !BREAK_IRQ && !RESET_REQ;
    endsequence

    chk_wait_entry: assert property (@(posedge MCLK) disable iff (!RSTN)
        run_wait_exec |=> CPU_ANS.clear_mask
            && s_q.pm == exc_pkg::PM_WAIT)
        else $error("wait entry wrong"); // RULE13
    chk_stop_entry: assert property (@(posedge MCLK) disable iff (!RSTN)
        run_stop_exec |=> CPU_ANS.clear_mask
            && s_q.pm == exc_pkg::PM_STOP && s_q.rec_cnt == 13'h0000)
        else $error("stop entry mask wrong"); // RULE13
    chk_wait_wake: assert property (@(posedge MCLK) disable iff (!RSTN)
        wait_wake |=> CPU_ANS.take_int && s_q.pm == exc_pkg::PM_RUN)
        else $error("wait wake missing"); // RULE15
    chk_wait_break: assert property (@(posedge MCLK) disable iff (!RSTN)
        wait_break |=> CPU_ANS.enter_break && s_q.wait_exit)
        else $error("break from wait wrong"); // RULE16
    chk_break_vector: assert property (@(posedge MCLK) disable iff (!RSTN)
        run_break |=> CPU_ANS.enter_break
            && CPU_ANS.vector == exc_pkg::VEC_SOFTWARE_INT)
        else $error("break vector wrong"); // RULE9
    chk_hw_masked: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_q.pm == exc_pkg::PM_RUN && CPU_REQ.int_mask && !CPU_REQ.swi_exec
            && !BREAK_IRQ && !RESET_REQ |=> !CPU_ANS.take_int)
        else $error("masked interrupt taken"); // RULE23
    chk_hw_stack: assert property (@(posedge MCLK) disable iff (!RSTN)
        run_hw_take |=> CPU_ANS.take_int
            && CPU_ANS.stack_pc == $past(CPU_REQ.pc) - 16'h0001)
        else $error("hardware stack pc wrong"); // RULE2
    chk_stop_hold: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_q.pm == exc_pkg::PM_STOP |-> s_q.rec_cnt == 13'h0000)
        else $error("counter ran in stop"); // RULE22
    chk_stop_stays: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_q.pm == exc_pkg::PM_STOP && !any_hw && !RESET_REQ
            |=> s_q.pm == exc_pkg::PM_STOP)
        else $error("stop left without cause"); // RULE20
    chk_stop_clocks: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_q.pm == exc_pkg::PM_STOP |-> !CPU_CLK_EN && !PERIPH_CLK_EN)
        else $error("clocks run in stop"); // RULE13 RULE18
    chk_pend_mid_map: assert property (@(posedge MCLK) disable iff (!RSTN)
        pend_mid == IRQ_PENDING[13:6])
        else $error("mid status map wrong"); // RULE5
    chk_flag_follow: assert property (@(posedge MCLK) disable iff (!RSTN)
        pend_high[5:0] == IRQ_PENDING[19:14])
        else $error("high flags do not follow"); // RULE7
    chk_status_ro: assert property (@(posedge MCLK) disable iff (!RSTN)
        AVS_WRITE && AVS_ADDRESS == exc_pkg::OFS_PEND_LOW
            |=> s_q.option == $past(s_q.option)
            && s_q.clear_en == $past(s_q.clear_en))
        else $error("status write had effect"); // RULE24
    chk_clear_outside: assert property (@(posedge MCLK) disable iff (!RSTN)
        !BREAK_ACTIVE && FLAG_CLEAR_REQ |-> FLAG_CLEAR_ALLOW)
        else $error("clear blocked outside break"); // RULE12
    chk_watchdog_wait: assert property (@(posedge MCLK) disable iff (!RSTN)
        s_q.pm == exc_pkg::PM_WAIT
            && !s_q.option[exc_pkg::POS_WDOG_DISABLE] |-> WATCHDOG_EN)
        else $error("watchdog off in wait"); // RULE17
    chk_read_answer: assert property (@(posedge MCLK) disable iff (!RSTN)
        AVS_READ && !s_q.rvalid |=> s_q.rvalid)
        else $error("read not answered"); // RULE24
endmodule // exc_power_unit

// File: verilog/exc_pkg.sv
// package: constants and carrier types for the exception and power unit
package exc_pkg;
    localparam int NUM_SRC = 20;
    // register offsets
    localparam logic [15:0] OFS_PEND_LOW = 16'hFE04;
    localparam logic [15:0] OFS_PEND_MID = 16'hFE05;
    localparam logic [15:0] OFS_PEND_HIGH = 16'hFE06;
    localparam logic [15:0] OFS_BRK_STATUS = 16'hFE00;
    localparam logic [15:0] OFS_BRK_FLAG_CTRL = 16'hFE03;
    localparam logic [15:0] OFS_OPTION = 16'hFE1F;
    // field positions
    localparam int POS_PEND_LOW = 2;
    localparam int POS_BRK_WAIT_EXIT = 1;
    localparam int POS_BRK_CLEAR_EN = 7;
    localparam int POS_SHORT_STOP = 7;
    localparam int POS_WDOG_DISABLE = 0;
    // reset values
    localparam logic [7:0] RST_OPTION = 8'h00;
    localparam logic [7:0] RST_BRK_FLAG_CTRL = 8'h00;
    // stop recovery in crystal clock cycles
    localparam int STOP_REC_LONG = 4096;
    localparam int STOP_REC_SHORT = 32;
    // vectors
    localparam logic [15:0] VEC_SOFTWARE_INT = 16'hFFFC;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_SRC_BASE = 16'hFFFA;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_WAIT,
        PM_STOP,
        PM_RECOVER
    } power_state_t;

    // cpu-side request carrier
    typedef struct packed {
        logic instr_end;
        logic swi_exec;
        logic wait_exec;
        logic stop_exec;
        logic int_mask;
        logic [15:0] pc;
    } cpu_req_t;

    // decision answer to the cpu
    typedef struct packed {
        logic take_int;
        logic [15:0] vector;
        logic [15:0] stack_pc;
        logic clear_mask;
        logic enter_break;
    } cpu_ans_t;
endpackage

// File: verification/cpu_core_model.sv
// cpu core model: issues instruction events and records the answers
`timescale 1ns/1ns
module cpu_core_model (
    // clock
    input wire logic clk,
    // answer in, request out
    input wire exc_pkg::cpu_ans_t ans,
    output exc_pkg::cpu_req_t req
);
    exc_pkg::cpu_ans_t last;
    int n_taken = 0;
    initial req = '0;
    always @(posedge clk) begin
        if (ans.take_int === 1'b1 || ans.enter_break === 1'b1) begin
            last <= ans;
            n_taken <= n_taken + 1;
        end
        if (ans.clear_mask === 1'b1) begin
            req.int_mask <= 1'b0;
        end
    end
    task automatic issue(input logic [3:0] k, input logic m,
            input logic [15:0] pc);
        @(posedge clk);
        {req.stop_exec, req.wait_exec, req.swi_exec, req.instr_end} <= k;
        req.int_mask <= m;
        req.pc <= pc;
        @(posedge clk);
        {req.stop_exec, req.wait_exec, req.swi_exec, req.instr_end} <= '0;
    endtask
endmodule // cpu_core_model

// File: verification/test_exc_power_unit.sv
// self-checking bench for the exception and power unit
`timescale 1ns/1ns
module test_exc_power_unit;
    localparam int REC_L = 16;
    localparam int REC_S = 4;
    logic mclk = 0, rstn = 0, rd = 0, wr = 0, rst_req = 0;
    logic brk_irq = 0, brk_act = 0, emu = 0, clr_req = 0;
    logic [15:0] addr = '0;
    logic [7:0] wdata = '0;
    logic [19:0] pend = '0, en = '0;
    logic [7:0] rdata;
    logic wreq, clr_ok, cpu_en, per_en, bus_en, xt_en, wd_en;
    logic [1:0] ps;
    exc_pkg::cpu_req_t req;
    exc_pkg::cpu_ans_t ans;
    int n_errors = 0, total_checks = 0;

    exc_power_unit #(.REC_LONG(REC_L), .REC_SHORT(REC_S)) exc_power_unit_i (
        .MCLK(mclk), .RSTN(rstn), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wreq), .IRQ_PENDING(pend), .IRQ_ENABLE(en),
        .RESET_REQ(rst_req), .CPU_REQ(req), .CPU_ANS(ans),
        .BREAK_IRQ(brk_irq), .BREAK_ACTIVE(brk_act), .EMULATION_MODE(emu),
        .FLAG_CLEAR_REQ(clr_req), .FLAG_CLEAR_ALLOW(clr_ok),
        .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en), .BUS_CLK_EN(bus_en),
        .XTAL_CLK_EN(xt_en), .WATCHDOG_EN(wd_en), .POWER_STATE(ps));
    cpu_core_model cpu_core_model_i (.clk(mclk), .ans(ans), .req(req));

    initial forever #2 mclk = ~mclk;

    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tmo();
        n_errors++;
        results();
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a,
            input logic [7:0] d, output logic [7:0] q);
        int i;
        @(posedge mclk);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (wreq === 1'b0) break;
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20) tmo();
    endtask
    task automatic wait_take(input int b, output int c);
        for (c = 0; c < 60; c++) begin
            @(posedge mclk);
            if (cpu_core_model_i.n_taken != b) break;
        end
        if (c == 60) tmo();
    endtask
    task automatic t_regs();
        logic [19:0] p;
        logic [7:0] q;
        for (int k = 0; k <= 20; k++) begin
            p = (k == 20) ? 20'hFFFFF : 20'h00001 << k;
            @(posedge mclk);
            pend <= p;
            acc(1'b0, exc_pkg::OFS_PEND_LOW, 8'h00, q);
            chk(q, {p[5:0], 2'b00});
            acc(1'b0, exc_pkg::OFS_PEND_MID, 8'h00, q);
            chk(q, p[13:6]);
            acc(1'b0, exc_pkg::OFS_PEND_HIGH, 8'h00, q);
            chk(q, {2'b00, p[19:14]});
        end
        acc(1'b1, exc_pkg::OFS_PEND_LOW, 8'h03, q);
        acc(1'b0, exc_pkg::OFS_PEND_LOW, 8'h00, q);
        chk(q, 8'hFC);
        acc(1'b0, 16'h0010, 8'h00, q);
        chk(q, exc_pkg::READ_UNMAPPED);
        pend <= '0;
        $display("test regs done");
    endtask
    task automatic t_swi();
        int b, c;
        for (int m = 0; m < 2; m++) begin
            b = cpu_core_model_i.n_taken;
            @(posedge mclk);
            pend <= 20'h00001;
            en <= 20'hFFFFF;
            cpu_core_model_i.issue(4'b0011, m[0], 16'h4000);
            wait_take(b, c);
            chk(cpu_core_model_i.last.vector,
                exc_pkg::VEC_SOFTWARE_INT);
            chk(cpu_core_model_i.last.stack_pc, 16'h4000);
            pend <= '0;
        end
        $display("test swi done");
    endtask
    task automatic t_hw();
        int b, c;
        b = cpu_core_model_i.n_taken;
        @(posedge mclk);
        pend <= 20'h000A0;
        cpu_core_model_i.issue(4'b0001, 1'b1, 16'h1234);
        en <= 20'hFFF5F;
        cpu_core_model_i.issue(4'b0001, 1'b0, 16'h1234);
        repeat (3) @(posedge mclk);
        chk(cpu_core_model_i.n_taken, b);
        en <= 20'hFFFFF;
        cpu_core_model_i.issue(4'b0001, 1'b0, 16'h1234);
        wait_take(b, c);
        chk(cpu_core_model_i.last.vector, 16'hFFF0);
        chk(cpu_core_model_i.last.stack_pc, 16'h1233);
        pend <= '0;
        $display("test hw done");
    endtask
    task automatic t_wait();
        int b, c;
        b = cpu_core_model_i.n_taken;
        cpu_core_model_i.issue(4'b0100, 1'b1, 16'h0300);
        @(posedge mclk);
        chk(ans.clear_mask, 1'b1);
        chk({ps, cpu_en, per_en, wd_en}, 5'b01011);
        pend <= 20'h00010;
        wait_take(b, c);
        chk(c <= 2, 1'b1);
        chk(cpu_core_model_i.last.vector, 16'hFFF2);
        pend <= '0;
        $display("test wait done");
    endtask
    task automatic t_stop(input logic s, input int rec);
        int b, c;
        logic [7:0] q;
        acc(1'b1, exc_pkg::OFS_OPTION, {s, 7'h00}, q);
        b = cpu_core_model_i.n_taken;
        cpu_core_model_i.issue(4'b1000, 1'b0, 16'h0200);
        @(posedge mclk);
        chk(ans.clear_mask, 1'b1);
        chk({ps, cpu_en, bus_en, xt_en}, 5'b10000);
        repeat (2 * rec) @(posedge mclk);
        chk(cpu_core_model_i.n_taken, b);
        pend <= 20'h00001;
        wait_take(b, c);
        chk(c >= rec && c <= rec + 4, 1'b1);
        pend <= '0;
        repeat (2) @(posedge mclk);
        chk({ps, bus_en}, 3'b001);
        $display("test stop done");
    endtask
    task automatic t_rst();
        int b, c;
        b = cpu_core_model_i.n_taken;
        cpu_core_model_i.issue(4'b1000, 1'b0, 16'h0200);
        rst_req <= 1'b1;
        @(posedge mclk);
        rst_req <= 1'b0;
        @(posedge mclk);
        chk({ps, bus_en, cpu_en}, 4'b0011);
        wait_take(b, c);
        chk(cpu_core_model_i.last.vector, exc_pkg::VEC_RESET);
        $display("test reset done");
    endtask
    task automatic t_break();
        int b, c;
        logic [7:0] q;
        b = cpu_core_model_i.n_taken;
        brk_irq <= 1'b1;
        cpu_core_model_i.issue(4'b0001, 1'b1, 16'h0700);
        brk_irq <= 1'b0;
        wait_take(b, c);
        chk(cpu_core_model_i.last.vector, exc_pkg::VEC_SOFTWARE_INT);
        brk_act <= 1'b1;
        clr_req <= 1'b1;
        @(posedge mclk);
        chk(clr_ok, 1'b0);
        acc(1'b1, exc_pkg::OFS_BRK_FLAG_CTRL, 8'h80, q);
        @(posedge mclk);
        chk(clr_ok, 1'b1);
        acc(1'b1, exc_pkg::OFS_BRK_FLAG_CTRL, 8'h00, q);
        brk_act <= 1'b0;
        emu <= 1'b1;
        @(posedge mclk);
        chk(clr_ok, 1'b1);
        b = cpu_core_model_i.n_taken;
        cpu_core_model_i.issue(4'b0100, 1'b0, 16'h0500);
        brk_irq <= 1'b1;
        @(posedge mclk);
        brk_irq <= 1'b0;
        wait_take(b, c);
        @(posedge mclk);
        chk(ps, 2'd0);
        acc(1'b0, exc_pkg::OFS_BRK_STATUS, 8'h00, q);
        chk(q[1], 1'b1);
        $display("test break done");
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        rstn <= 1'b1;
        t_regs();
        t_swi();
        t_hw();
        t_wait();
        t_stop(1'b0, REC_L);
        t_stop(1'b1, REC_S);
        t_rst();
        t_break();
        results();
    end
endmodule // test_exc_power_unit
